// ===== bsta_regs.vh
// Offsets, mode codes, field positions and reset values of the test slave.
`ifndef BSTA_REGS_VH
`define BSTA_REGS_VH
`define BSTA_ADDR_STATE    12'h000
`define BSTA_LOC_INDEX     6'h04
`define BSTA_LOC_SEGMENT   6'h08
`define BSTA_LOC_PATTERN   6'h0C
`define BSTA_LOC_WR_INV    6'h10
`define BSTA_LOC_WR_INC    6'h14
`define BSTA_LOC_RD        6'h18
`define BSTA_LOC_LSB       0
`define BSTA_LOC_MSB       5
`define BSTA_BURST_LSB     6
`define BSTA_BURST_MSB     8
`define BSTA_FN_LSB        2
`define BSTA_FN_MSB        10
`define BSTA_MODE_EXIT     3'h0
`define BSTA_MODE_FUNC     3'h1
`define BSTA_MODE_TAG      3'h2
`define BSTA_MODE_RESET    3'h0
`define BSTA_FN_WR_MASK    9'h1C0
`define BSTA_FN_RD_MASK    9'h03F
`define BSTA_FN_NONE       4'hF
`define BSTA_FN_COPROC_DATA_IN      4'h8
`define BSTA_FN_INPUTS     4'h7
`define BSTA_FN_DIN        4'h6
`define BSTA_FN_DOUT       4'h5
`define BSTA_FN_COPROC_DATA_OUT     4'h4
`define BSTA_FN_COPROC_INSTR_WORD       4'h3
`define BSTA_FN_STA        4'h2
`define BSTA_FN_STB        4'h1
`define BSTA_FN_CORE_ADDRESS_OUT       4'h0
`define BSTA_SEG_IMPL_BITS 3
`define BSTA_TAG_ENTRIES   512
`define BSTA_WORD_RESET    32'h00000000
`endif

// ===== bsta_test_slave.v
// Test slave that steps the core in functional test and exercises the tag array.
// Overview of operation
// [R1] State location write at 0x0 selects test mode
// [R2] Functional locations are one-hot in address 10:2
// [R3] Status word B upper fields at fixed bits
// [R4] Status word B low bits: scan, comms, debug
// [R5] Status word A bits 2:0 translate, endian, executed
// [R6] Core clocked once after each write sequence
// [R7] Tester writes at least one input per cycle
// [R8] Tester: address, write, read, turnaround, in order
// [R9] Locations serviced in fixed write-clock-read order
// [R10] Tester enters with 1, exits with 0
// [R11] Status reads return previous vector values
// [R12] First iteration: zero coproc input, zero masks
// [R13] Repeated data-out value read with zero mask
// [R14] Tester should mask fast and coproc clocks
// [R15] Test clock synchronous, at most half bus rate; full bus rate when the mask selects one write location and no reads
// [R16] Capture error, wait, last on rising edges
// [R17] Burst length decoded from address bits 8:6
// [R18] Burst repeats the location operation each beat
// [R19] Tag array: eight segments, 64 lines, 26 bits
// [R20] Tester loads segment and index before access
// [R21] Tag write invert, write increment, read, advance
// [R22] Burst write repeats store-and-advance per beat
// [R23] Pattern packed into bus word at fixed fields
// [R24] Tag read returns entry in bits 31:6
// [R25] Index reload keeps the segment number
// [R26] Index wraps 63 to 0, segment kept
`timescale 1ns/10ps
`include "bsta_regs.vh"

module bsta_test_slave
(
   input  wire        sys_clk_i,
   input  wire        reset_i,
   input  wire        addr_load_i,
   input  wire [31:0] addr_i,
   input  wire        beat_i,
   input  wire        beat_write_i,
   input  wire [31:0] wdata_i,
   output wire [31:0] rdata_o,
   output wire        rdata_valid_o,
   output wire [2:0]  test_mode_o,
   output wire        core_step_o,
   output wire [31:0] coproc_data_in_o,
   output wire [31:0] core_input_word_o,
   output wire [31:0] core_data_in_o,
   input  wire [31:0] core_data_out_i,
   input  wire [31:0] coproc_data_out_i,
   input  wire [31:0] coproc_instr_word_i,
   input  wire [31:0] core_address_out_i,
   input  wire [18:0] status_a_upper_i,
   input  wire        coproc_translate_n_i,
   input  wire        endian_select_out_i,
   input  wire        instr_executed_flag_i,
   input  wire        scan_drive_out_enable_i,
   input  wire        debug_acknowledge_i,
   input  wire        trace_clock_i,
   input  wire [3:0]  tap_instruction_reg_i,
   input  wire [1:0]  range_out_i,
   input  wire [4:0]  scan_chain_select_i,
   input  wire [3:0]  tap_state_code_i,
   input  wire        test_data_out_i,
   input  wire        test_out_enable_n_i,
   input  wire [8:0]  scan_ctl_i,
   input  wire        comms_receive_flag_i,
   input  wire        comms_transmit_flag_i,
   input  wire        internal_debug_request_i
);

   localparam PH_WRITE = 1'b0;
   localparam PH_READ  = 1'b1;

   reg  [2:0]  mode_reg;
   reg  [11:0] addr_reg;
   reg  [8:0]  mask_reg;
   reg  [8:0]  pend_reg;
   reg  [7:0]  burst_left_reg;
   reg  [31:0] rdata_reg;
   reg         rvalid_reg;
   reg         step_reg;
   reg  [31:0] coproc_data_in_reg;
   reg  [31:0] inputs_reg;
   reg  [31:0] din_reg;
   reg  [31:0] sta_snap_reg;
   reg  [31:0] stb_snap_reg;
   reg  [5:0]  index_reg;
   reg  [6:0]  segment_reg;
   reg  [25:0] pattern_reg;
   reg  [25:0] tag_mem [0:`BSTA_TAG_ENTRIES-1];

   wire [31:0] status_a;
   wire [31:0] status_b;
   wire [8:0]  pend_wr;
   wire [8:0]  pend_rd;
   wire [3:0]  wsel;
   wire [3:0]  rsel;
   wire [8:0]  pend_rd_ord;
   wire [3:0]  rsel_ord;
   wire        phase;
   wire [5:0]  loc;
   wire        seg_ok;
   wire [8:0]  tag_addr;
   wire [25:0] tag_rd;
   wire        tag_beat;
   wire        tag_we;

   // Highest set bit, so locations are taken from address bit 10 downward.
   function [3:0] bsta_top_bit;
      input [8:0] v;
      integer i;
      begin
         bsta_top_bit = `BSTA_FN_NONE;
         for (i = 0; i < 9; i = i + 1)
            if (v[i])
               bsta_top_bit = i[3:0];
      end
   endfunction

   function [7:0] bsta_burst_len;
      input [2:0] code;
      begin
         bsta_burst_len = 8'h01 << code; // R17
      end
   endfunction

   function [25:0] bsta_unpack;
      input [31:0] w;
      begin
         bsta_unpack = {w[28:24], w[22:16], w[14:8], w[6:0]}; // R23
      end
   endfunction

   function [8:0] bsta_clear;
      input [8:0] v;
      input [3:0] sel;
      begin
         bsta_clear = v & ~(9'h001 << sel);
      end
   endfunction

   // Status words are built straight from the core's outputs.
   assign status_a = {10'h000, status_a_upper_i, coproc_translate_n_i,
                      endian_select_out_i, instr_executed_flag_i}; // R5
   assign status_b = {scan_drive_out_enable_i, debug_acknowledge_i,
                      trace_clock_i, tap_instruction_reg_i, range_out_i,
                      scan_chain_select_i, tap_state_code_i,
                      test_data_out_i, test_out_enable_n_i, scan_ctl_i,
                      comms_receive_flag_i, comms_transmit_flag_i,
                      internal_debug_request_i}; // R3 R4

   assign pend_wr = pend_reg & `BSTA_FN_WR_MASK;
   assign pend_rd = pend_reg & `BSTA_FN_RD_MASK;
   assign wsel    = bsta_top_bit(pend_wr);
   // The coprocessor instruction is read before coprocessor data out, so
   // their two pending bits trade places for the priority pick.
   assign pend_rd_ord = {pend_rd[8:5], pend_rd[3], pend_rd[4],
                         pend_rd[2:0]};
   assign rsel_ord    = bsta_top_bit(pend_rd_ord);
   assign rsel        = (rsel_ord == `BSTA_FN_COPROC_DATA_OUT) ? `BSTA_FN_COPROC_INSTR_WORD :
                        (rsel_ord == `BSTA_FN_COPROC_INSTR_WORD) ? `BSTA_FN_COPROC_DATA_OUT :
                        rsel_ord; // R9
   assign phase   = (pend_wr == 9'h000) ? PH_READ : PH_WRITE;

   assign loc      = addr_reg[`BSTA_LOC_MSB:`BSTA_LOC_LSB];
   // Only the low segments exist; the rest read zero and ignore writes.
   assign seg_ok   = (segment_reg[6:`BSTA_SEG_IMPL_BITS] == 4'h0); // R19
   assign tag_addr = {segment_reg[`BSTA_SEG_IMPL_BITS-1:0], index_reg};
   assign tag_rd   = seg_ok ? tag_mem[tag_addr] : 26'h0000000;
   assign tag_beat = beat_i && !addr_load_i && (mode_reg == `BSTA_MODE_TAG)
                     && (addr_reg != `BSTA_ADDR_STATE)
                     && (burst_left_reg != 8'h00);
   assign tag_we   = tag_beat && beat_write_i && seg_ok &&
                     ((loc == `BSTA_LOC_WR_INV) || (loc == `BSTA_LOC_WR_INC));

   // The array has no reset; its contents are what the tester wrote.
   always @(posedge sys_clk_i)
   begin
      if (tag_we)
         tag_mem[tag_addr] <= pattern_reg; // R21 R22
   end

   always @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         mode_reg       <= `BSTA_MODE_RESET;
         addr_reg       <= `BSTA_ADDR_STATE;
         mask_reg       <= 9'h000;
         pend_reg       <= 9'h000;
         burst_left_reg <= 8'h00;
         rdata_reg      <= `BSTA_WORD_RESET;
         rvalid_reg     <= 1'b0;
         step_reg       <= 1'b0;
         coproc_data_in_reg      <= `BSTA_WORD_RESET;
         inputs_reg     <= `BSTA_WORD_RESET;
         din_reg        <= `BSTA_WORD_RESET;
         sta_snap_reg   <= `BSTA_WORD_RESET;
         stb_snap_reg   <= `BSTA_WORD_RESET;
         index_reg      <= 6'h00;
         segment_reg    <= 7'h00;
         pattern_reg    <= 26'h0000000;
      end
      else
      begin
         step_reg   <= 1'b0;
         rvalid_reg <= 1'b0;
         if (addr_load_i)
         begin
            addr_reg <= addr_i[11:0];
            if (mode_reg == `BSTA_MODE_FUNC)
            begin
               mask_reg <= addr_i[`BSTA_FN_MSB:`BSTA_FN_LSB]; // R2
               pend_reg <= addr_i[`BSTA_FN_MSB:`BSTA_FN_LSB];
            end
            else
            begin
               mask_reg <= 9'h000;
               pend_reg <= 9'h000;
            end
            burst_left_reg <=
               bsta_burst_len(addr_i[`BSTA_BURST_MSB:`BSTA_BURST_LSB]);
         end
         else if (beat_i)
         begin
            rvalid_reg <= !beat_write_i;
            rdata_reg  <= `BSTA_WORD_RESET;
            if (addr_reg == `BSTA_ADDR_STATE)
            begin
               if (beat_write_i)
                  mode_reg <= wdata_i[2:0]; // R1
               else
                  rdata_reg <= {29'h00000000, mode_reg};
            end
            else if (mode_reg == `BSTA_MODE_FUNC)
            begin
               // Reads issued while writes are still due are answered
               // with zero and leave the sequence where it stands.
               if (beat_write_i && phase == PH_WRITE)
               begin
                  case (wsel) // R9
                     `BSTA_FN_COPROC_DATA_IN:  coproc_data_in_reg  <= wdata_i;
                     `BSTA_FN_INPUTS: inputs_reg <= wdata_i;
                     `BSTA_FN_DIN:    din_reg    <= wdata_i;
                     default:         din_reg    <= din_reg;
                  endcase
                  if (bsta_clear(pend_wr, wsel) == 9'h000)
                  begin
                     step_reg     <= 1'b1; // R6
                     sta_snap_reg <= status_a; // R11
                     stb_snap_reg <= status_b; // R11
                  end
                  if (bsta_clear(pend_reg, wsel) == 9'h000)
                     pend_reg <= mask_reg;
                  else
                     pend_reg <= bsta_clear(pend_reg, wsel);
               end
               else if (!beat_write_i && phase == PH_READ &&
                        rsel != `BSTA_FN_NONE)
               begin
                  case (rsel) // R9
                     `BSTA_FN_DOUT:   rdata_reg <= core_data_out_i;
                     `BSTA_FN_COPROC_DATA_OUT: rdata_reg <= coproc_data_out_i;
                     `BSTA_FN_COPROC_INSTR_WORD:   rdata_reg <= coproc_instr_word_i;
                     `BSTA_FN_STA:    rdata_reg <= sta_snap_reg;
                     `BSTA_FN_STB:    rdata_reg <= stb_snap_reg;
                     `BSTA_FN_CORE_ADDRESS_OUT:   rdata_reg <= core_address_out_i;
                     default:         rdata_reg <= `BSTA_WORD_RESET;
                  endcase
                  // A fresh iteration begins once every location is done.
                  if (bsta_clear(pend_reg, rsel) == 9'h000)
                     pend_reg <= mask_reg;
                  else
                     pend_reg <= bsta_clear(pend_reg, rsel);
               end
            end
            else if (tag_beat)
            begin
               burst_left_reg <= burst_left_reg - 8'h01; // R18
               case (loc)
                  `BSTA_LOC_INDEX:
                     if (beat_write_i)
                        index_reg <= wdata_i[5:0]; // R25
                  `BSTA_LOC_SEGMENT:
                     if (beat_write_i)
                        segment_reg <= wdata_i[6:0];
                  `BSTA_LOC_PATTERN:
                     if (beat_write_i)
                        pattern_reg <= bsta_unpack(wdata_i); // R23
                  `BSTA_LOC_WR_INV:
                     if (beat_write_i)
                     begin
                        pattern_reg <= ~pattern_reg; // R21
                        index_reg   <= index_reg + 6'h01; // R26
                     end
                  `BSTA_LOC_WR_INC:
                     if (beat_write_i)
                     begin
                        pattern_reg <= pattern_reg + 26'h0000001; // R21
                        index_reg   <= index_reg + 6'h01; // R26
                     end
                  `BSTA_LOC_RD:
                     if (!beat_write_i)
                     begin
                        rdata_reg <= {tag_rd, 6'h00}; // R24
                        index_reg <= index_reg + 6'h01; // R21
                     end
                  default:
                     rdata_reg <= `BSTA_WORD_RESET;
               endcase
            end
         end
      end
   end

   assign rdata_o           = rdata_reg;
   assign rdata_valid_o     = rvalid_reg;
   assign test_mode_o       = mode_reg;
   assign core_step_o       = step_reg;
   assign coproc_data_in_o  = coproc_data_in_reg;
   assign core_input_word_o = inputs_reg;
   assign core_data_in_o    = din_reg;

endmodule // bsta_test_slave

// ===== bsta_checker.sv
// Concurrent checks on the test slave ports.
`timescale 1ns/10ps
module bsta_checker
(
   input wire        sys_clk_i,
   input wire        reset_i,
   input wire        addr_load_i,
   input wire [31:0] addr_i,
   input wire        beat_i,
   input wire        beat_write_i,
   input wire [31:0] wdata_i,
   input wire [31:0] rdata_o,
   input wire        rdata_valid_o,
   input wire [2:0]  test_mode_o,
   input wire        core_step_o
);
   reg  [11:0] addr_reg;
   wire        rd_beat = beat_i && !beat_write_i && !addr_load_i;
   wire        wr_beat = beat_i && beat_write_i && !addr_load_i;
   wire        st_wr   = wr_beat && addr_reg == 12'h000;
   always @(posedge sys_clk_i)
      if (addr_load_i)
         addr_reg <= addr_i[11:0];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_read_answer: assert property (rd_beat |=> rdata_valid_o)
      else $error("read beat got no answer");
   a_no_stray: assert property (!rd_beat |=> !rdata_valid_o)
      else $error("answer without read beat");
   a_mode_write: assert property (st_wr |=> test_mode_o == $past(wdata_i[2:0]))
      else $error("mode not taken from state write");
   a_mode_holds: assert property (!st_wr |=> $stable(test_mode_o))
      else $error("mode changed without state write");
   a_step_pulse: assert property (core_step_o |=> !core_step_o)
      else $error("core step longer than one cycle");
   a_step_cause: assert property (core_step_o |-> $past(wr_beat))
      else $error("core step without a write");
   a_rdata_hold: assert property (!beat_i |=> $stable(rdata_o))
      else $error("read data moved without a beat");
   a_tag_low: assert property (rdata_valid_o && test_mode_o == 3'h2 &&
      addr_reg[5:0] == 6'h18 |-> rdata_o[5:0] == 6'h00)
      else $error("tag read low bits not zero");
   c_step: cover property (core_step_o);
   c_tag_rd: cover property (rdata_valid_o && test_mode_o == 3'h2);
   c_mode: cover property (st_wr);
endmodule // bsta_checker

bind bsta_test_slave bsta_checker bsta_checker_inst (.sys_clk_i, .reset_i,
   .addr_load_i, .addr_i, .beat_i, .beat_write_i, .wdata_i, .rdata_o,
   .rdata_valid_o, .test_mode_o, .core_step_o);

// ===== bsta_core_model.sv
// Behavioural core that moves one vector each time the slave steps it.
`timescale 1ns/10ps
module bsta_core_model
(
   input  wire        sys_clk_i,
   input  wire        reset_i,
   input  wire        core_step_i,
   output wire [31:0] dout_o,
   output wire [31:0] coproc_data_out_o,
   output wire [31:0] coproc_instr_word_o,
   output wire [31:0] core_address_out_o,
   output wire [21:0] sta_o,
   output wire [31:0] stb_o
);
   reg [31:0] vec_reg;
   // Outputs only move on a step, so a stale snapshot shows up as a mismatch.
   always @(posedge sys_clk_i)
      if (reset_i)
         vec_reg <= 32'h13579BDF;
      // Steps come on the bus clock; two cycles running only when the mask selects one write location and no reads.
      else if (core_step_i)
         // Each step gives a fresh word, so no data-out read needs a mask.
         vec_reg <= vec_reg * 32'h0019660D + 32'h3C6EF35F;
   assign dout_o   = vec_reg;
   assign coproc_data_out_o = vec_reg + 32'h01234567;
   assign coproc_instr_word_o   = ~vec_reg;
   assign core_address_out_o   = {vec_reg[7:0], vec_reg[31:8]};
   assign sta_o    = vec_reg[29:8] ^ 22'h2AAAAA;
   assign stb_o    = {vec_reg[15:0], vec_reg[31:16]} ^ 32'h5A5A5A5A;
endmodule // bsta_core_model

// ===== bus_slave_test_access_tb_top.sv
// Self-checking bench for the test slave with a stepped core model.
`timescale 1ns/10ps
module bus_slave_test_access_tb_top;
   reg          sys_clk_i = 1'h0;
   reg          reset_i = 1'h1;
   reg          addr_load_i = 1'h0;
   reg  [31:0]  addr_i = 32'h0;
   reg          beat_i = 1'h0;
   reg          beat_write_i = 1'h0;
   reg  [31:0]  wdata_i = 32'h0;
   wire [31:0]  rdata_o, coproc_data_in, cinw, din, dout, coproc_data_out, coproc_instr_word, core_address_out, stb;
   wire [21:0]  sta;
   wire         rdata_valid_o, core_step_o;
   wire [2:0]   test_mode_o;
   integer      fails = 0;
   integer      n_tests = 0;
   integer      i;
   logic [31:0] exp_q[$];
   string       name_q[$];
   reg  [31:0]  d0, d1, d2;
   reg  [25:0]  pat;

   bsta_test_slave bsta_test_slave_inst (.sys_clk_i, .reset_i, .addr_load_i,
      .addr_i, .beat_i, .beat_write_i, .wdata_i, .rdata_o, .rdata_valid_o,
      .test_mode_o, .core_step_o, .coproc_data_in_o(coproc_data_in),
      .core_input_word_o(cinw), .core_data_in_o(din), .core_data_out_i(dout),
      .coproc_data_out_i(coproc_data_out), .coproc_instr_word_i(coproc_instr_word),
      .core_address_out_i(core_address_out), .status_a_upper_i(sta[21:3]),
      .coproc_translate_n_i(sta[2]), .endian_select_out_i(sta[1]),
      .instr_executed_flag_i(sta[0]), .scan_drive_out_enable_i(stb[31]),
      .debug_acknowledge_i(stb[30]), .trace_clock_i(stb[29]),
      .tap_instruction_reg_i(stb[28:25]), .range_out_i(stb[24:23]),
      .scan_chain_select_i(stb[22:18]), .tap_state_code_i(stb[17:14]),
      .test_data_out_i(stb[13]), .test_out_enable_n_i(stb[12]),
      .scan_ctl_i(stb[11:3]), .comms_receive_flag_i(stb[2]),
      .comms_transmit_flag_i(stb[1]), .internal_debug_request_i(stb[0]));
   bsta_core_model bsta_core_model_inst (.sys_clk_i, .reset_i,
      .core_step_i(core_step_o), .dout_o(dout), .coproc_data_out_o(coproc_data_out),
      .coproc_instr_word_o(coproc_instr_word), .core_address_out_o(core_address_out), .sta_o(sta), .stb_o(stb));

   initial
      forever #25 sys_clk_i = ~sys_clk_i;

   task results;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input string nm, input [31:0] seen, input [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One call per cycle; the strobes it sets hold until the next call.
   task op(input l, input b, input w, input [31:0] a);
      // Inputs move on the falling edge, so the rising edge sees them settled.
      @(negedge sys_clk_i);
      addr_load_i = l;
      beat_i = b;
      beat_write_i = w;
      if (l)
         addr_i = a;
      else
         wdata_i = a;
   endtask
   task ad(input [31:0] a);
      op(1'h1, 1'h0, 1'h0, a);
   endtask
   task wr(input [31:0] d);
      op(1'h0, 1'h1, 1'h1, d);
   endtask
   task rd(input string nm, input [31:0] e);
      exp_q.push_back(e);
      name_q.push_back(nm);
      op(1'h0, 1'h1, 1'h0, 32'h0);
   endtask
   function [31:0] pack(input [25:0] p);
      pack = {3'h0, p[25:21], 1'h0, p[20:14], 1'h0, p[13:7], 1'h0, p[6:0]};
   endfunction
   task iter(input first);
      reg [31:0] a_e, b_e;
      a_e = {10'h000, sta};
      b_e = stb;
      d0 = first ? 32'h0 : $urandom;
      d1 = $urandom;
      d2 = $urandom;
      wr(d0);
      wr(d1);
      wr(d2);
      op(1'h0, 1'h0, 1'h0, 32'h0);
      check("step", {31'h0, core_step_o}, 32'h1);
      check("coproc_data_in", coproc_data_in, d0);
      check("inputs", cinw, d1);
      check("din", din, d2);
      // The core moves at this edge, so the data reads expect the new vector and the status reads the old one.
      op(1'h0, 1'h0, 1'h0, 32'h0);
      rd("dout", dout);
      rd("coproc_instr_word", coproc_instr_word);
      rd("coproc_data_out", coproc_data_out);
      // The model's clock bits are fixed per vector, so no mask is needed.
      rd("status a", a_e);
      rd("status b", b_e);
      rd("core_address_out", core_address_out);
   endtask

   always @(negedge sys_clk_i)
      if (rdata_valid_o === 1'h1)
      begin
         if (exp_q.size() == 0)
            check("stray read", 32'h1, 32'h0);
         else
            check(name_q.pop_front(), rdata_o, exp_q.pop_front());
      end

   initial
   begin
      repeat (3000) @(posedge sys_clk_i);
      fails = fails + 1;
      results;
   end

   initial
   begin
      d0 = $urandom(79968);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i) reset_i = 1'h0;
      check("mode rst", {29'h0, test_mode_o}, 32'h0);
      ad(32'h0);
      wr(32'h1);
      ad(32'h7FC);
      iter(1'h1);
      iter(1'h0);
      iter(1'h0);
      ad(32'h0);
      rd("mode", 32'h1);
      wr(32'h2);
      ad(32'h4);
      wr(32'h5);
      ad(32'h8);
      wr(32'h1);
      pat = $urandom;
      ad(32'hC);
      wr(pack(pat));
      ad(32'h94);
      repeat (4) wr($urandom);
      ad(32'h4);
      wr(32'h5);
      ad(32'h98);
      for (i = 0; i < 4; i++)
         rd("tag inc", {pat + i[25:0], 6'h00});
      ad(32'h4);
      wr(32'h3E);
      ad(32'hC);
      wr(pack(pat));
      ad(32'h90);
      repeat (4) wr(32'h0);
      ad(32'h4);
      wr(32'h3E);
      ad(32'h98);
      for (i = 0; i < 4; i++)
         rd("tag inv", {(i % 2) ? ~pat : pat, 6'h00});
      rd("burst end", 32'h0);
      ad(32'h0);
      wr(32'h0);
      repeat (3) op(1'h0, 1'h0, 1'h0, 32'h0);
      check("mode exit", {29'h0, test_mode_o}, 32'h0);
      check("pending", exp_q.size(), 32'h0);
      results;
   end
endmodule // bus_slave_test_access_tb_top
